/* File: hdl/dcf_fifo_flags.sv */
`timescale 1ns/1ps
`include "dcf_defs.svh"
`default_nettype none

module dcf_fifo_flags #(
  parameter int unsigned DEPTH = `DCF_DEPTH
) (
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic        reset_n_i,
  input  wire logic        wclk_i,
  input  wire logic        rclk_i,
  input  wire logic [8:0]  write_data_i,
  input  wire logic        write_enable_a_n_i,
  input  wire logic        write_enable_b_or_load_i,
  input  wire logic        read_enable_a_n_i,
  input  wire logic        read_enable_b_n_i,
  output logic      [8:0]  read_data_out_o,
  output logic             read_data_oe_o,
  output logic             full_n_o,
  output logic             almost_full_n_o,
  output logic             almost_empty_n_o,
  output logic             empty_n_o,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [15:0] DEPTH16 = 16'(DEPTH);
  localparam logic [15:0] OFS_MASK = 16'(DEPTH - 1);

  // Pin synchroniser: all pins take the same two stages so data stays aligned with
  // the clock edges found; bits are reset, wclk, rclk, enables, data
  logic [15:0] sync1_ff;
  logic [15:0] sync2_ff;
  logic [1:0]  clk_prev_ff;
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sync1_ff    <= 16'h0000;
      sync2_ff    <= 16'h0000;
      clk_prev_ff <= 2'b00;
    end else begin
      sync1_ff    <= {reset_n_i, wclk_i, rclk_i, write_enable_a_n_i, write_enable_b_or_load_i,
                      read_enable_a_n_i, read_enable_b_n_i, write_data_i};
      sync2_ff    <= sync1_ff;
      clk_prev_ff <= sync2_ff[14:13];
    end
  end

  logic             pin_rst;
  logic             wclk_rise;
  logic             rclk_rise;
  logic             wea_n;
  logic             web_ld;
  logic             rd_en;
  dcf_pkg::dcf_word_t wdata;
  assign pin_rst   = ~sync2_ff[15];
  assign wclk_rise = sync2_ff[14] & ~clk_prev_ff[1];
  assign rclk_rise = sync2_ff[13] & ~clk_prev_ff[0];
  assign wea_n     = sync2_ff[12];
  assign web_ld    = sync2_ff[11];
  assign rd_en     = ~sync2_ff[10] & ~sync2_ff[9];
  assign wdata     = sync2_ff[8:0];

  // Storage array, no reset needed since the pointers guard every word
  dcf_pkg::dcf_word_t mem [DEPTH];

  logic [AW:0]        wr_ptr_ff;
  logic [AW:0]        rd_ptr_ff;
  logic [1:0]         wr_idx_ff;
  logic [1:0]         rd_idx_ff;
  dcf_pkg::dcf_ofs_t  ofs_ff [4];
  dcf_pkg::dcf_mode_e mode_ff;
  dcf_pkg::dcf_word_t dout_ff;
  logic               full_n_ff;
  logic               afull_n_ff;
  logic               aempty_n_ff;
  logic               empty_n_ff;
  logic [AW:0]        nxt_wr_ptr;
  logic [AW:0]        nxt_rd_ptr;
  logic [1:0]         nxt_wr_idx;
  logic [1:0]         nxt_rd_idx;
  dcf_pkg::dcf_ofs_t  nxt_ofs [4];
  dcf_pkg::dcf_mode_e nxt_mode;
  dcf_pkg::dcf_word_t nxt_dout;
  logic               nxt_full_n;
  logic               nxt_afull_n;
  logic               nxt_aempty_n;
  logic               nxt_empty_n;

  logic        fifo_rst;
  logic        load_sel;
  logic        wr_go;
  logic        rd_go;
  logic        ofs_wr;
  logic        ofs_rd;
  logic [AW:0] fill;
  logic [15:0] fill_aft;
  logic [AW:0] fill_nxt;
  logic [AW:0] fill_w;
  logic [AW:0] fill_r;
  logic [15:0] e_off;
  logic [15:0] f_off;
  logic [15:0] af_lvl;

  // Request decode; capacity checks use the true fill so a lagging flag can never
  // let a write overrun or a read underrun
  always_comb begin
    fifo_rst = srst_i | pin_rst;
    load_sel = (mode_ff == dcf_pkg::DCF_MODE_LOAD) & ~web_ld;
    fill     = wr_ptr_ff - rd_ptr_ff;
    wr_go    = wclk_rise & ~wea_n & web_ld & (16'(fill) != DEPTH16);
    rd_go    = rclk_rise & rd_en & ~load_sel & (fill != '0);
    ofs_wr   = wclk_rise & ~wea_n & load_sel;
    ofs_rd   = rclk_rise & rd_en & load_sel;
    if (mode_ff == dcf_pkg::DCF_MODE_EXPAND) begin
      e_off = `DCF_OFS_DEFAULT;
      f_off = `DCF_OFS_DEFAULT;
    end else begin
      e_off = {ofs_ff[1], ofs_ff[0]} & OFS_MASK;
      f_off = {ofs_ff[3], ofs_ff[2]} & OFS_MASK;
    end
    af_lvl = DEPTH16 - f_off;
  end

  // Next state of pointers, offsets, output register and the four flags
  always_comb begin
    nxt_wr_ptr   = wr_ptr_ff;
    nxt_rd_ptr   = rd_ptr_ff;
    nxt_wr_idx   = wr_idx_ff;
    nxt_rd_idx   = rd_idx_ff;
    nxt_ofs      = ofs_ff;
    nxt_mode     = mode_ff;
    nxt_dout     = dout_ff;
    nxt_full_n   = full_n_ff;
    nxt_afull_n  = afull_n_ff;
    nxt_aempty_n = aempty_n_ff;
    nxt_empty_n  = empty_n_ff;
    if (wr_go) begin
      nxt_wr_ptr = wr_ptr_ff + 1'b1;
    end
    if (rd_go) begin
      nxt_rd_ptr = rd_ptr_ff + 1'b1;
      nxt_dout   = mem[rd_ptr_ff[AW-1:0]];
    end
    if (ofs_wr) begin
      nxt_ofs[wr_idx_ff] = wdata[7:0];
      nxt_wr_idx         = wr_idx_ff + 2'b01;
    end
    if (ofs_rd) begin
      nxt_dout   = {1'b0, ofs_ff[rd_idx_ff]};
      nxt_rd_idx = rd_idx_ff + 2'b01;
    end
    // Differences at pointer width, so wrap-around stays modulo twice the depth
    fill_nxt = nxt_wr_ptr - nxt_rd_ptr;
    fill_w   = wr_ptr_ff - nxt_rd_ptr;
    fill_r   = nxt_wr_ptr - rd_ptr_ff;
    fill_aft = 16'(fill_nxt);
    // A read seen between two write edges only shows on the next write edge: the
    // allowed one-edge lag, bought for flags that never glitch between edges.
    // Almost flags judge the fill before this edge's own transfer, so a write on
    // the edge where almost-full falls leaves full minus (m-1); reads alike
    if (wclk_rise) begin
      nxt_full_n  = (fill_aft != DEPTH16);
      nxt_afull_n = (16'(fill_w) < af_lvl);
    end
    if (rclk_rise) begin
      nxt_empty_n  = (fill_aft != 16'h0000);
      nxt_aempty_n = (16'(fill_r) > e_off);
    end
    // Pin role is caught while reset is held; both clocks may run meanwhile
    if (pin_rst) begin
      nxt_mode = web_ld ? dcf_pkg::DCF_MODE_EXPAND : dcf_pkg::DCF_MODE_LOAD;
    end
    if (fifo_rst) begin
      nxt_wr_ptr   = '0;
      nxt_rd_ptr   = '0;
      nxt_wr_idx   = 2'b00;
      nxt_rd_idx   = 2'b00;
      nxt_ofs[0]   = `DCF_OFS_LSB_RST;
      nxt_ofs[1]   = `DCF_OFS_MSB_RST;
      nxt_ofs[2]   = `DCF_OFS_LSB_RST;
      nxt_ofs[3]   = `DCF_OFS_MSB_RST;
      nxt_dout     = 9'h000;
      nxt_full_n   = 1'b1;
      nxt_afull_n  = 1'b1;
      nxt_aempty_n = 1'b0;
      nxt_empty_n  = 1'b0;
    end
    if (srst_i) begin
      nxt_mode = dcf_pkg::DCF_MODE_LOAD;
    end
  end

  always_ff @(posedge mclk_i) begin
    wr_ptr_ff   <= nxt_wr_ptr;
    rd_ptr_ff   <= nxt_rd_ptr;
    wr_idx_ff   <= nxt_wr_idx;
    rd_idx_ff   <= nxt_rd_idx;
    ofs_ff      <= nxt_ofs;
    mode_ff     <= nxt_mode;
    dout_ff     <= nxt_dout;
    full_n_ff   <= nxt_full_n;
    afull_n_ff  <= nxt_afull_n;
    aempty_n_ff <= nxt_aempty_n;
    empty_n_ff  <= nxt_empty_n;
  end

  // Storage write
  always_ff @(posedge mclk_i) begin
    if (wr_go) begin
      mem[wr_ptr_ff[AW-1:0]] <= wdata;
    end
  end

  // APB slave: no wait states, answer in the first access cycle
  logic        oe_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic        nxt_oe;
  logic        nxt_pready;
  logic        nxt_pslverr;
  logic [31:0] nxt_prdata;
  logic [31:0] status_w;
  logic [31:0] offset_w;
  logic        hit;

  always_comb begin
    status_w                   = 32'h0000_0000;
    status_w[`DCF_ST_FULL_N]   = full_n_ff;
    status_w[`DCF_ST_AFULL_N]  = afull_n_ff;
    status_w[`DCF_ST_AEMPTY_N] = aempty_n_ff;
    status_w[`DCF_ST_EMPTY_N]  = empty_n_ff;
    status_w[`DCF_ST_MODE]     = (mode_ff == dcf_pkg::DCF_MODE_EXPAND);
    status_w[`DCF_ST_FILL +: 13] = 13'(fill);
    offset_w                   = 32'h0000_0000;
    offset_w[`DCF_OFS_EMPTY +: 16] = e_off;
    offset_w[`DCF_OFS_FULL +: 16]  = f_off;
    nxt_oe      = oe_ff;
    nxt_pready  = psel_i & ~penable_i;
    nxt_pslverr = 1'b0;
    nxt_prdata  = 32'h0000_0000;
    hit         = 1'b0;
    case (paddr_i)
      `DCF_REG_CTRL: begin
        hit        = 1'b1;
        nxt_prdata = {31'h0, oe_ff};
      end
      `DCF_REG_STATUS: begin
        hit        = ~pwrite_i;
        nxt_prdata = status_w;
      end
      `DCF_REG_OFFSET: begin
        hit        = ~pwrite_i;
        nxt_prdata = offset_w;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    // Unmapped or read-only targets answer with an error and zero data
    if (!nxt_pready || pwrite_i || !hit) begin
      nxt_prdata = 32'h0000_0000;
    end
    if (nxt_pready) begin
      nxt_pslverr = ~hit;
    end
    if (psel_i && penable_i && pready_ff && pwrite_i && paddr_i == `DCF_REG_CTRL) begin
      nxt_oe = pwdata_i[`DCF_CTRL_OE];
    end
    if (srst_i) begin
      nxt_oe      = `DCF_CTRL_OE_RST;
      nxt_pready  = 1'b0;
      nxt_pslverr = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    oe_ff      <= nxt_oe;
    pready_ff  <= nxt_pready;
    pslverr_ff <= nxt_pslverr;
    prdata_ff  <= nxt_prdata;
  end

  // Outputs straight from flops
  assign read_data_out_o  = dout_ff;
  assign read_data_oe_o   = oe_ff;
  assign full_n_o         = full_n_ff;
  assign almost_full_n_o  = afull_n_ff;
  assign almost_empty_n_o = aempty_n_ff;
  assign empty_n_o        = empty_n_ff;
  assign prdata_o         = prdata_ff;
  assign pready_o         = pready_ff;
  assign pslverr_o        = pslverr_ff;

  // Checks; reset of either kind suspends them
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (fifo_rst);

  a_full_at_depth: assert property (wclk_rise && fill_aft == DEPTH16 |=> !full_n_ff)
    else $error("Full flag not low at depth");
  a_fill_bounded: assert property (16'(fill) <= DEPTH16)
    else $error("Fill count passed the depth");
  a_wside_edges: assert property (!wclk_rise |=> $stable(full_n_ff) && $stable(afull_n_ff))
    else $error("Write-side flag moved off a write edge");
  a_rside_edges: assert property (!rclk_rise |=> $stable(empty_n_ff) && $stable(aempty_n_ff))
    else $error("Read-side flag moved off a read edge");
  a_empty_equal: assert property (rclk_rise && nxt_rd_ptr == nxt_wr_ptr |=> !empty_n_ff)
    else $error("Empty flag not low with equal pointers");
  a_afull_level: assert property (wclk_rise |=>
    afull_n_ff == ($past(16'(fill_w)) < $past(af_lvl)))
    else $error("Almost-full flag off its threshold");
  a_aempty_level: assert property (rclk_rise |=>
    aempty_n_ff == ($past(16'(fill_r)) > $past(e_off)))
    else $error("Almost-empty flag off its threshold");
  a_mode_held: assert property (!pin_rst |=> $stable(mode_ff))
    else $error("Pin role changed outside reset");
  a_expand_default: assert property (mode_ff == dcf_pkg::DCF_MODE_EXPAND |-> e_off == 16'h0007 && f_off == 16'h0007)
    else $error("Expansion mode thresholds not at default");
  a_ofs_wrap: assert property (ofs_wr && wr_idx_ff == 2'b11 |=> wr_idx_ff == 2'b00)
    else $error("Offset write sequence did not wrap");
  a_read_blocked: assert property (rclk_rise && rd_en && fill == '0 |=> $stable(rd_ptr_ff))
    else $error("Read taken while empty");

  c_fill_full: cover property (!full_n_ff);
  c_drain_empty: cover property (rd_go ##1 !empty_n_ff);
  c_ofs_load: cover property (ofs_wr && wr_idx_ff == 2'b11);
  c_apb_write: cover property (psel_i && penable_i && pready_ff && pwrite_i);

endmodule // dcf_fifo_flags

`default_nettype wire

/* File: inc/dcf_defs.svh */
`ifndef DCF_DEFS_SVH
`define DCF_DEFS_SVH
// Storage depth, one of 64, 256, 512, 1024, 2048, 4096
`define DCF_DEPTH 64
// Offset register reset values: low byte 7, high byte 0
`define DCF_OFS_LSB_RST 8'h07
`define DCF_OFS_MSB_RST 8'h00
`define DCF_OFS_DEFAULT 16'h0007
// APB register byte addresses
`define DCF_REG_CTRL 12'h000
`define DCF_REG_STATUS 12'h004
`define DCF_REG_OFFSET 12'h008
// Control field: data bus output enable, driving after srst_i, unchanged by a pin reset
`define DCF_CTRL_OE 0
`define DCF_CTRL_OE_RST 1'b1
// Status fields
`define DCF_ST_FULL_N 0
`define DCF_ST_AFULL_N 1
`define DCF_ST_AEMPTY_N 2
`define DCF_ST_EMPTY_N 3
`define DCF_ST_MODE 4
`define DCF_ST_FILL 16
// Offset register fields
`define DCF_OFS_EMPTY 0
`define DCF_OFS_FULL 16
`endif

/* File: inc/dcf_pkg.sv */
package dcf_pkg;
  // Role of the dual-purpose enable/load pin, caught at reset
  typedef enum logic {DCF_MODE_LOAD, DCF_MODE_EXPAND} dcf_mode_e;
  typedef logic [8:0] dcf_word_t;
  typedef logic [7:0] dcf_ofs_t;
endpackage

/* File: sim/dcf_link_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Producer and consumer logic on the two link ports
module dcf_link_model (
  output logic       wclk_o,
  output logic       rclk_o,
  output logic [8:0] wdata_o,
  output logic       wen_n_o,
  output logic       ren_n_o
);
  // Idle pins: clocks low, enables off
  initial begin
    wclk_o = 1'b0;
    rclk_o = 1'b0;
    wdata_o = 9'h000;
    wen_n_o = 1'b1;
    ren_n_o = 1'b1;
  end
  // One 400 ns cycle; edges sit 13 ns off mclk so no sample races them
  task automatic cyc(input logic w, input logic r, input logic [8:0] d);
    #13;
    wdata_o = w ? d : ~wdata_o;  // Unused bus toggles, never shows stale data
    wen_n_o = ~w;
    ren_n_o = ~r;  // Drives both read enables
    #50 wclk_o = 1'b1;
    #100 rclk_o = 1'b1;
    #100 wclk_o = 1'b0;
    #100 rclk_o = 1'b0;
    #37;
  endtask
endmodule  // dcf_link_model
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`include "dcf_defs.svh"
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t ns: got %h want %h", $time, (a), (b)); end end
module tb_top;
  localparam int DEPTH = 64;
  logic        mclk_i, srst_i, reset_n_i, wb_pin, psel_i, penable_i, pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd, sx;
  logic        pready_o, pslverr_o, er, read_data_oe_o;
  logic        full_n_o, almost_full_n_o, almost_empty_n_o, empty_n_o;
  logic [8:0]  read_data_out_o, write_data_i, last;
  logic        wclk_i, rclk_i, write_enable_a_n_i, read_enable_a_n_i;
  logic [8:0]  q[$];
  logic [7:0]  ob[5] = '{8'h03, 8'h00, 8'h05, 8'h00, 8'h02};
  int          nn, mm, err_count, tests_run;
  int          seed = 32'h0000_fb89;

  dcf_fifo_flags #(.DEPTH(DEPTH)) dut (
    .mclk_i, .srst_i, .reset_n_i, .wclk_i, .rclk_i, .write_data_i,
    .write_enable_a_n_i, .write_enable_b_or_load_i(wb_pin), .read_enable_a_n_i,
    .read_enable_b_n_i(read_enable_a_n_i), .read_data_out_o, .read_data_oe_o,
    .full_n_o, .almost_full_n_o, .almost_empty_n_o, .empty_n_o,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o);
  dcf_link_model u_lnk (.wclk_o(wclk_i), .rclk_o(rclk_i), .wdata_o(write_data_i),
    .wen_n_o(write_enable_a_n_i), .ren_n_o(read_enable_a_n_i));

  // System clock, 50 ns
  always #25 mclk_i = ~mclk_i;

  // Expected status word from the bench model
  function automatic logic [31:0] st_exp(input logic md);
    int f;
    f = q.size();
    return {3'h0, 13'(f), 11'h000, md, logic'(f != 0), logic'(f > nn),
            logic'(f < DEPTH - mm), logic'(f != DEPTH)};
  endfunction

  task automatic test_done;
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic tend(input string s);
    $display("test %s done at %0t ns", s, $time);
  endtask

  // APB master; waits for pready under a bound, never assumes a latency
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    logic rdy;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    k = 0;
    // Answer taken as it stands before the sampling edge, never in the edge's own step
    do begin
      @(negedge mclk_i);
      k++;
      rdy = pready_o;
      r = prdata_o;
      e = pslverr_o;
      @(posedge mclk_i);
    end while (rdy !== 1'b1 && k < 50);
    if (rdy !== 1'b1) begin
      err_count++;
      test_done;
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0000_0000, rd, er);
    `CHK(rd, x)
    `CHK(er, xe)
  endtask

  // Flags against the model fill; an idle link cycle has passed first
  // One-device width group: the composite flags are this device's own
  task automatic chk_flags;
    sx = st_exp(1'b0);
    `CHK({empty_n_o, almost_empty_n_o, almost_full_n_o, full_n_o}, sx[3:0])
  endtask

  // Reset with link clocks and enables busy; pin level picks the mode
  task automatic do_reset(input logic pin);
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    srst_i <= 1'b1;
    wb_pin <= pin;
    repeat (16) @(posedge mclk_i);
    srst_i <= 1'b0;
    u_lnk.cyc(1'b1, 1'b1, 9'h1a5);
    @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    wb_pin <= 1'b1;
    q.delete();
    nn = 7;
    mm = 7;
    last = 9'h000;
    u_lnk.cyc(1'b0, 1'b0, 9'h000);
    chk_flags;
    `CHK(read_data_out_o, 9'h000)
  endtask

  // One link operation, then an idle cycle so both sides settle
  task automatic op(input logic w, input logic r);
    logic [8:0] d;
    d = 9'($random(seed));
    u_lnk.cyc(w, r, d);
    u_lnk.cyc(1'b0, 1'b0, d);
    if (w && q.size() < DEPTH) q.push_back(d);
    if (r) begin
      if (q.size() > 0) last = q.pop_front();
      `CHK(read_data_out_o, last)
    end
    chk_flags;
  endtask

  // Offset byte through the load pin; a read checks it on the data outputs
  task automatic ld(input logic r, input logic [7:0] b);
    @(posedge mclk_i);
    wb_pin <= 1'b0;
    @(posedge mclk_i);
    u_lnk.cyc(~r, r, {1'b0, b});
    @(posedge mclk_i);
    wb_pin <= 1'b1;
    if (r) `CHK(read_data_out_o, {1'b0, b})
  endtask

  // Hang guard
  initial begin
    #1_000_000;
    err_count++;
    test_done;
  end

  // Main sequence
  initial begin
    mclk_i = 1'b0;
    srst_i = 1'b1;
    reset_n_i = 1'b0;
    wb_pin = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0000_0000;
    do_reset(1'b0);
    `CHK(read_data_oe_o, 1'b1)
    rchk(`DCF_REG_STATUS, st_exp(1'b0), 1'b0);
    rchk(`DCF_REG_OFFSET, 32'h0007_0007, 1'b0);
    tend("reset");
    foreach (ob[i]) ld(1'b0, ob[i]);
    nn = 2;
    mm = 5;
    rchk(`DCF_REG_OFFSET, 32'h0005_0002, 1'b0);
    for (int i = 0; i < 4; i++) ld(1'b1, (i == 0) ? ob[4] : ob[i]);
    tend("load");
    repeat (DEPTH + 1) op(1'b1, 1'b0);
    rchk(`DCF_REG_STATUS, st_exp(1'b0), 1'b0);
    repeat (DEPTH + 1) op(1'b0, 1'b1);
    tend("fill");
    apb(1'b1, `DCF_REG_CTRL, 32'h0000_0000, rd, er);
    @(posedge mclk_i);
    `CHK(read_data_oe_o, 1'b0)
    rchk(`DCF_REG_CTRL, 32'h0000_0000, 1'b0);
    rchk(12'h00c, 32'h0000_0000, 1'b1);
    apb(1'b1, `DCF_REG_STATUS, 32'hffff_ffff, rd, er);
    `CHK(er, 1'b1)
    tend("apb");
    do_reset(1'b1);
    ld(1'b0, 8'h01);
    rchk(`DCF_REG_OFFSET, 32'h0007_0007, 1'b0);
    repeat (9) op(1'b1, 1'b0);
    rchk(`DCF_REG_STATUS, st_exp(1'b1), 1'b0);
    do_reset(1'b0);
    rchk(`DCF_REG_STATUS, st_exp(1'b0), 1'b0);
    tend("expand");
    test_done;
  end
endmodule  // tb_top
`default_nettype wire
